// ==== hw/listen_seq_consts.vh ====
// Constants for the listen sequencer: register offsets, fields, resets.
// Included by listen_sequencer_and_reset.v; definitions only.
`ifndef LISTEN_SEQ_CONSTS_VH
`define LISTEN_SEQ_CONSTS_VH

// Register byte addresses
`define ADDR_SEQ_CTRL      8'h00
`define ADDR_SEQ_CONFIG    8'h04
`define ADDR_SLEEP_TIMER   8'h08
`define ADDR_WINDOW_TIMER  8'h0C
`define ADDR_RX_TIMEOUT    8'h10
`define ADDR_PIN_MAP       8'h14
`define ADDR_STATUS        8'h18

// Control register bits
`define CTRL_START_BIT     0
`define CTRL_STOP_BIT      1
`define CTRL_ROUTE_BIT     2

// Config register fields
`define CFG_IDLE_BIT       0
`define CFG_START_LSB      1
`define CFG_LOWP_BIT       3
`define CFG_IDLE_TR_BIT    4
`define CFG_RX_TR_LSB      5
`define CFG_TO_TR_LSB      8

// Field codes
`define FROM_RX_SYNC       3'b101
`define FROM_RX_PREAMBLE   3'b110
`define FROM_TO_LOWPOWER   2'b10
`define MAP_PREAMBLE       2'b11

// Reset values
`define CFG_RESET          32'h0000_0000
`define TIMER_RESET        16'h0010
`define MAP_RESET          10'h000

// Ready delay after reset release, in ns, and derived cycles
`define READY_DELAY_NS     1000
`define CLK_PERIOD_NS      20
`define READY_CYCLES       ((`READY_DELAY_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
// Reference clock output divider terminal count; each half period lasts this value plus one cycle
`define REF_CLOCK_OUTPUT_HALF        4'h1

`endif

// ==== hw/listen_sequencer_and_reset.v ====
// Listen-mode top sequencer with reset readiness and reference clock out.
// Assumes a Wishbone classic master on ref_clk; detector flags from pins.
//
// Behaviour
// - Reset acts on its own at power-up; no host action is needed.
// - Reference clock output toggles only once the device is ready.
// - Listen keeps radio idle on RC clock, waking receiver periodically.
// - Interrupt request raised toward host on packet reception.
// - Preamble wake stops sequencer, radio stays in Receive.
// - No signal: wake every sum of timers, receive for second timer.
// - Preamble flag routes to output pin 4 with code 11 and select bit.
// - Receive transition 110 stays in Receive on preamble found.
// - Second timer bounds Receive while no preamble is found.
// - Polling windows start every first plus second timer interval.
// - Sync wake opens a window bounded by receive timeout.
// - Preamble before timeout keeps Receive until second timer ends.
// - Sync match fires interrupt, stops sequencer, stays in Receive.
//
// Our own choices: the Wishbone interface to the registers and the placing of the registers.
`timescale 1ns/1ps
`include "listen_seq_consts.vh"

module listen_sequencer_and_reset (
    input  wire        ref_clk,
    input  wire        rst,
    input  wire        rc_tick,
    input  wire        reset_input_low,
    input  wire        preamble_found_flag,
    input  wire        sync_word_match_flag,
    input  wire        payload_complete_flag,
    input  wire        checksum_pass_flag,
    input  wire        queue_threshold_flag,
    input  wire        queue_drained_flag,
    input  wire [7:0]  wb_adr_i,
    input  wire [31:0] wb_dat_i,
    input  wire [3:0]  wb_sel_i,
    input  wire        wb_we_i,
    input  wire        wb_cyc_i,
    input  wire        wb_stb_i,
    output reg  [31:0] wb_dat_o,
    output reg         wb_ack_o,
    output reg         ref_clock_output,
    output reg         rx_enable,
    output reg         rc_only,
    output reg  [4:0]  general_output_pin,
    output reg         irq
);

    localparam [2:0] ST_OFF  = 3'd0;
    localparam [2:0] ST_IDLE = 3'd1;
    localparam [2:0] ST_RX   = 3'd2;
    localparam [2:0] ST_STAY = 3'd3;
    localparam [2:0] ST_WAIT = 3'd4;
    localparam integer READY_LAST = `READY_CYCLES - 1;

    // Synchronisers for pins
    reg  [6:0]  sync1_reg;
    reg  [6:0]  sync2_reg;
    reg         rc_prev_reg;
    wire        rc_edge = sync2_reg[0] & ~rc_prev_reg;
    wire        nrst_s  = sync2_reg[1];
    wire        pre_s   = sync2_reg[2];
    wire        syn_s   = sync2_reg[3];
    wire        pay_s   = sync2_reg[4];

    reg  [31:0] cfg_reg;
    reg  [15:0] t1_reg;
    reg  [15:0] t2_reg;
    reg  [15:0] to_reg;
    reg  [9:0]  map_reg;
    reg         route_reg;
    reg  [2:0]  state_reg;
    reg  [15:0] cnt_reg;
    reg         pre_seen_reg;
    reg  [2:0]  evt_reg;
    reg  [7:0]  ready_cnt_reg;
    reg         ready_reg;
    reg  [3:0]  div_reg;
    reg         start_pulse;
    reg         stop_pulse;
    reg         queue_drained_q1;
    reg         queue_drained_q;

    wire        wr      = wb_cyc_i & wb_stb_i & wb_we_i & ~wb_ack_o;
    wire        rd_take = wb_cyc_i & wb_stb_i & ~wb_ack_o;
    wire [2:0]  from_rx = cfg_reg[`CFG_RX_TR_LSB +: 3];
    wire [1:0]  from_to = cfg_reg[`CFG_TO_TR_LSB +: 2];

    function [1:0] map_code;
        input [9:0] m;
        input [2:0] idx;
        begin
            map_code = m[idx*2 +: 2];
        end
    endfunction

    function [15:0] merge16;
        input [15:0] old;
        input [31:0] d;
        input [3:0]  s;
        begin
            merge16 = {s[1] ? d[15:8] : old[15:8],
                       s[0] ? d[7:0]  : old[7:0]};
        end
    endfunction

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            sync1_reg   <= 7'h00;
            sync2_reg   <= 7'h00;
            rc_prev_reg <= 1'b0;
        end else begin
            sync1_reg   <= {queue_threshold_flag, checksum_pass_flag,
                            payload_complete_flag, sync_word_match_flag,
                            preamble_found_flag, reset_input_low, rc_tick};
            sync2_reg   <= sync1_reg;
            rc_prev_reg <= sync2_reg[0];
        end
    end

    // Readiness after reset; clock out starts only when ready
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            ready_cnt_reg    <= 8'h00;
            ready_reg        <= 1'b0;
            div_reg          <= 4'h0;
            ref_clock_output <= 1'b0;
        end else if (!nrst_s) begin
            ready_cnt_reg    <= 8'h00;
            ready_reg        <= 1'b0;
            ref_clock_output <= 1'b0;
        end else if (!ready_reg) begin
            ready_cnt_reg <= ready_cnt_reg + 8'h01;
            if (ready_cnt_reg == READY_LAST[7:0])
                ready_reg <= 1'b1;
        end else begin
            if (div_reg == `REF_CLOCK_OUTPUT_HALF) begin
                div_reg          <= 4'h0;
                ref_clock_output <= ~ref_clock_output;
            end else begin
                div_reg <= div_reg + 4'h1;
            end
        end
    end

    // Register slave
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            cfg_reg     <= `CFG_RESET;
            t1_reg      <= `TIMER_RESET;
            t2_reg      <= `TIMER_RESET;
            to_reg      <= `TIMER_RESET;
            map_reg     <= `MAP_RESET;
            route_reg   <= 1'b0;
            wb_ack_o    <= 1'b0;
            wb_dat_o    <= 32'h0000_0000;
            start_pulse <= 1'b0;
            stop_pulse  <= 1'b0;
        end else begin
            wb_ack_o    <= rd_take;
            start_pulse <= 1'b0;
            stop_pulse  <= 1'b0;
            if (wr) begin
                if (wb_adr_i == `ADDR_SEQ_CTRL) begin
                    if (wb_sel_i[0]) begin
                        start_pulse <= wb_dat_i[`CTRL_START_BIT];
                        stop_pulse  <= wb_dat_i[`CTRL_STOP_BIT];
                        route_reg   <= wb_dat_i[`CTRL_ROUTE_BIT];
                    end
                end else if (wb_adr_i == `ADDR_SEQ_CONFIG) begin
                    cfg_reg[15:0] <= merge16(cfg_reg[15:0], wb_dat_i,
                                             wb_sel_i);
                end else if (wb_adr_i == `ADDR_SLEEP_TIMER) begin
                    t1_reg <= merge16(t1_reg, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == `ADDR_WINDOW_TIMER) begin
                    t2_reg <= merge16(t2_reg, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == `ADDR_RX_TIMEOUT) begin
                    to_reg <= merge16(to_reg, wb_dat_i, wb_sel_i);
                end else if (wb_adr_i == `ADDR_PIN_MAP) begin
                    map_reg <= wb_dat_i[9:0];
                end
            end
            if (rd_take && !wb_we_i) begin
                if (wb_adr_i == `ADDR_SEQ_CTRL)
                    wb_dat_o <= {29'h0, route_reg, 2'b00};
                else if (wb_adr_i == `ADDR_SEQ_CONFIG)
                    wb_dat_o <= {16'h0000, cfg_reg[15:0]};
                else if (wb_adr_i == `ADDR_SLEEP_TIMER)
                    wb_dat_o <= {16'h0000, t1_reg};
                else if (wb_adr_i == `ADDR_WINDOW_TIMER)
                    wb_dat_o <= {16'h0000, t2_reg};
                else if (wb_adr_i == `ADDR_RX_TIMEOUT)
                    wb_dat_o <= {16'h0000, to_reg};
                else if (wb_adr_i == `ADDR_PIN_MAP)
                    wb_dat_o <= {22'h0, map_reg};
                else if (wb_adr_i == `ADDR_STATUS)
                    wb_dat_o <= {24'h0, ready_reg, pre_seen_reg,
                                 evt_reg, state_reg};
                else
                    wb_dat_o <= 32'h0000_0000;
            end
        end
    end

    // Sequencer; timers advance on RC ticks only
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            state_reg    <= ST_OFF;
            cnt_reg      <= 16'h0000;
            pre_seen_reg <= 1'b0;
            evt_reg      <= 3'b000;
            rx_enable    <= 1'b0;
            rc_only      <= 1'b0;
            irq          <= 1'b0;
        end else begin
            irq <= 1'b0;
            if (stop_pulse) begin
                state_reg <= ST_OFF;
                rx_enable <= 1'b0;
                rc_only   <= 1'b0;
            end else if (start_pulse) begin
                state_reg    <= ST_IDLE;
                cnt_reg      <= 16'h0000;
                pre_seen_reg <= 1'b0;
                evt_reg      <= 3'b000;
                rx_enable    <= 1'b0;
                rc_only      <= cfg_reg[`CFG_IDLE_BIT];
            end else begin
                case (state_reg)
                ST_IDLE: begin
                    if (rc_edge) begin
                        if (cnt_reg >= t1_reg - 16'h0001) begin
                            state_reg    <= ST_RX;
                            cnt_reg      <= 16'h0000;
                            pre_seen_reg <= 1'b0;
                            rx_enable    <= 1'b1;
                            rc_only      <= 1'b0;
                        end else begin
                            cnt_reg <= cnt_reg + 16'h0001;
                        end
                    end
                end
                ST_RX: begin
                    if (from_rx == `FROM_RX_PREAMBLE && pre_s) begin
                        state_reg  <= ST_STAY;
                        evt_reg[0] <= 1'b1;
                        irq        <= 1'b1;
                    end else if (from_rx == `FROM_RX_SYNC && syn_s) begin
                        state_reg  <= ST_STAY;
                        evt_reg[1] <= 1'b1;
                        irq        <= 1'b1;
                    end else begin
                        if (pre_s)
                            pre_seen_reg <= 1'b1;
                        if (rc_edge) begin
                            cnt_reg <= cnt_reg + 16'h0001;
                            if (cnt_reg >= t2_reg - 16'h0001) begin
                                state_reg <= ST_IDLE;
                                cnt_reg   <= 16'h0000;
                                rx_enable <= 1'b0;
                                rc_only   <= cfg_reg[`CFG_IDLE_BIT];
                            end else if (from_rx == `FROM_RX_SYNC &&
                                         !pre_seen_reg && !pre_s &&
                                         cnt_reg >= to_reg - 16'h0001 &&
                                         from_to == `FROM_TO_LOWPOWER) begin
                                state_reg <= ST_WAIT;
                                rx_enable <= 1'b0;
                                rc_only   <= cfg_reg[`CFG_IDLE_BIT];
                            end
                        end
                    end
                end
                ST_STAY: rx_enable <= 1'b1;
                ST_WAIT: begin
                    if (rc_edge) begin
                        if (cnt_reg >= t2_reg - 16'h0001) begin
                            state_reg <= ST_IDLE;
                            cnt_reg   <= 16'h0000;
                        end else begin
                            cnt_reg <= cnt_reg + 16'h0001;
                        end
                    end
                end
                default: begin
                    rx_enable <= 1'b0;
                    rc_only   <= 1'b0;
                end
                endcase
                if (pay_s && !evt_reg[2] &&
                    (state_reg == ST_RX || state_reg == ST_STAY)) begin
                    evt_reg[2] <= 1'b1;
                    irq        <= 1'b1;
                end
            end
        end
    end

    // Output pin mapping
    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            general_output_pin <= 5'h00;
        end else begin
            general_output_pin[0] <= (map_code(map_reg, 3'd0) == 2'b01) &
                                     sync2_reg[5];
            general_output_pin[1] <= (map_code(map_reg, 3'd1) == 2'b00) &
                                     sync2_reg[6];
            general_output_pin[2] <= (map_code(map_reg, 3'd2) ==
                                      `MAP_PREAMBLE) & syn_s;
            general_output_pin[3] <= (map_code(map_reg, 3'd3) == 2'b00) &
                                     queue_drained_q;
            general_output_pin[4] <= (map_code(map_reg, 3'd4) ==
                                      `MAP_PREAMBLE) & route_reg &
                                     pre_s;
        end
    end

    always @(posedge ref_clk or posedge rst) begin
        if (rst) begin
            queue_drained_q1 <= 1'b0;
            queue_drained_q  <= 1'b0;
        end else begin
            queue_drained_q1 <= queue_drained_flag;
            queue_drained_q  <= queue_drained_q1;
        end
    end

endmodule // listen_sequencer_and_reset

// ==== sim/listen_seq_checker.sv ====
// Port assertions for the listen sequencer top module.
// Bound from the test top; one clock, reset async active high.
`timescale 1ns/1ps
module listen_seq_checker (
    input wire ref_clk,
    input wire rst,
    input wire wb_cyc_i,
    input wire wb_stb_i,
    input wire wb_ack_o,
    input wire ref_clock_output,
    input wire rx_enable,
    input wire rc_only,
    input wire irq
);
    default clocking @(posedge ref_clk); endclocking
    default disable iff (rst);
    logic [7:0] up_cnt;
    // Cycles since reset release, saturating
    always @(posedge ref_clk or posedge rst)
        if (rst)
            up_cnt <= 8'h00;
        else if (up_cnt != 8'hFF)
            up_cnt <= up_cnt + 8'h01;
    sequence take_s; wb_cyc_i && wb_stb_i && !wb_ack_o; endsequence
    sequence stay_s; rx_enable [*4]; endsequence
    ack_resp_a: assert property (take_s |=> wb_ack_o)
        else $error("no ack after request");
    ack_one_a: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("ack held too long");
    clk_quiet_a: assert property (
        up_cnt < 8'h30 |-> !ref_clock_output)
        else $error("clock out before ready");
    clk_hold_a: assert property (
        $rose(ref_clock_output) |=> ref_clock_output)
        else $error("clock out high too short");
    irq_pulse_a: assert property (irq |=> !irq)
        else $error("event request longer than one cycle");
    rx_excl_a: assert property (!(rx_enable && rc_only))
        else $error("receive and idle sleep together");
    stay_rx_a: assert property (irq && rx_enable |=> stay_s)
        else $error("receiver dropped after event");
    reset_clear_a: assert property (
        $fell(rst) |-> !wb_ack_o && !irq && !rx_enable && !ref_clock_output)
        else $error("outputs not cleared by reset");
endmodule // listen_seq_checker

// ==== sim/rf_side_model.sv ====
// Far side: free-running RC oscillator tick and radio detector flags.
// Flags follow bench requests only while the receiver is on.
`timescale 1ns/1ps
module rf_side_model #(
    parameter int RCP = 8
) (
    input  wire  ref_clk,
    input  wire  rx_enable,
    input  wire  pre_on,
    input  wire  sync_on,
    input  wire  pay_on,
    output logic rc_tick,
    output logic preamble_found_flag,
    output logic sync_word_match_flag,
    output logic payload_complete_flag
);
    int         div;
    logic [3:0] pf_d;
    initial begin
        div = 0;
        pf_d = 4'h0;
        {rc_tick, preamble_found_flag, sync_word_match_flag} = 3'b000;
        payload_complete_flag = 1'b0;
    end
    // Sync word trails the preamble by a few cycles
    always @(posedge ref_clk) begin
        div <= (div == RCP - 1) ? 0 : div + 1;
        rc_tick <= (div < RCP / 2);
        preamble_found_flag <= pre_on && rx_enable;
        pf_d <= {pf_d[2:0], preamble_found_flag};
        sync_word_match_flag <= sync_on && pf_d[3] && rx_enable;
        payload_complete_flag <= pay_on && rx_enable;
    end
endmodule // rf_side_model

// ==== sim/listen_sequencer_and_reset_test.sv ====
// Self-checking bench for the listen sequencer and reset readiness.
// Drives Wishbone and pins; far side comes from rf_side_model.
`timescale 1ns/1ps
`include "listen_seq_consts.vh"
module listen_sequencer_and_reset_test;
    localparam int RCP = 8;
    localparam int T1 = 4;
    localparam int T2 = 6;
    logic        ref_clk, rst, reset_input_low, wb_we_i, wb_cyc_i, wb_stb_i;
    logic        checksum_pass_flag, queue_threshold_flag, queue_drained_flag;
    logic        pre_on, sync_on, pay_on, rc_tick, preamble_found_flag;
    logic        sync_word_match_flag, payload_complete_flag;
    logic        wb_ack_o, ref_clock_output, rx_enable, rc_only, irq;
    logic [3:0]  wb_sel_i = 4'hF;
    logic [7:0]  wb_adr_i;
    logic [31:0] wb_dat_i, wb_dat_o, rdat;
    logic [4:0]  general_output_pin;
    logic [2:0]  mon;
    int          err_count = 0;
    int          total_checks = 0;
    assign mon = {ref_clock_output, irq, rx_enable};
    listen_sequencer_and_reset u_dut (.*);
    rf_side_model #(.RCP(RCP)) u_rf (.*);
    initial begin
        ref_clk = 1'b0;
        forever #10 ref_clk = ~ref_clk;
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        total_checks++;
        if (seen !== exp) begin
            err_count++;
            $display("mismatch at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    task automatic print_verdict;
        if (err_count == 0 && total_checks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask
    task automatic give_up;
        check(32'h0000_0000, 32'h0000_0001);
        print_verdict;
    endtask
    task automatic wait_sig(input int k, input logic v, output int c);
        c = 0;
        do begin
            @(negedge ref_clk);
            if (++c > 3000)
                give_up;
        end while (mon[k] !== v);
    endtask
    task automatic wb(input logic [7:0] a, input logic w,
                      input logic [31:0] d);
        int n = 0;
        @(posedge ref_clk);
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} <= {2'b11, w, a, d};
        do begin
            @(posedge ref_clk);
            if (++n > 50)
                give_up;
        end while (wb_ack_o !== 1'b1);
        rdat = wb_dat_o;
        {wb_cyc_i, wb_stb_i} <= 2'b00;
    endtask
    task automatic poll(input int hi, input int per);
        int a, b, c;
        wait_sig(0, 1'b0, a);
        wait_sig(0, 1'b1, a);
        wait_sig(0, 1'b0, b);
        wait_sig(0, 1'b1, c);
        check(b, hi);
        check(b + c, per);
    endtask
    task automatic t_ready;
        int c;
        repeat (30) begin
            @(negedge ref_clk);
            check(ref_clock_output, 1'b0);
        end
        wait_sig(2, 1'b1, c);
        @(posedge ref_clk);
        reset_input_low <= 1'b0;
        repeat (20) @(posedge ref_clk);
        repeat (8) begin
            @(negedge ref_clk);
            check(ref_clock_output, 1'b0);
        end
        @(posedge ref_clk);
        reset_input_low <= 1'b1;
        wait_sig(2, 1'b1, c);
        check(c > 40, 1'b1);
    endtask
    task automatic t_regs;
        logic [7:0] a [3] = '{`ADDR_SLEEP_TIMER, `ADDR_WINDOW_TIMER,
                              `ADDR_RX_TIMEOUT};
        foreach (a[i]) begin
            wb(a[i], 1'b0, 32'h0000_0000);
            check(rdat, 32'h0000_0010);
        end
        wb(`ADDR_SEQ_CONFIG, 1'b0, 32'h0000_0000);
        check(rdat, 32'h0000_0000);
        wb(8'h1C, 1'b1, 32'hFFFF_FFFF);
        wb(8'h1C, 1'b0, 32'h0000_0000);
        check(rdat, 32'h0000_0000);
        wb(`ADDR_WINDOW_TIMER, 1'b1, T2);
        wb(`ADDR_SLEEP_TIMER, 1'b1, T1);
        wb(`ADDR_SLEEP_TIMER, 1'b0, 32'h0000_0000);
        check(rdat, T1);
    endtask
    task automatic t_nosig;
        int c;
        // Sleep idle, start to low power, idle to receive, 110 on preamble
        wb(`ADDR_SEQ_CONFIG, 1'b1, 32'h0000_00D9);
        wb(`ADDR_SEQ_CTRL, 1'b1, 32'h0000_0001);
        poll(T2 * RCP, (T1 + T2) * RCP);
        wait_sig(0, 1'b0, c);
        repeat (RCP) @(negedge ref_clk);
        check(rc_only, 1'b1);
        wb(`ADDR_SEQ_CTRL, 1'b1, 32'h0000_0002);
    endtask
    task automatic t_pre;
        int c;
        wb(`ADDR_PIN_MAP, 1'b1, 32'h0000_0300);
        wb(`ADDR_SEQ_CTRL, 1'b1, 32'h0000_0005);
        pre_on <= 1'b1;
        wait_sig(1, 1'b1, c);
        repeat (4) @(negedge ref_clk);
        check(general_output_pin[4], 1'b1);
        @(posedge ref_clk);
        pay_on <= 1'b1;
        wait_sig(1, 1'b1, c);
        wb(`ADDR_STATUS, 1'b0, 32'h0000_0000);
        check(rdat[5], 1'b1);
        check(rdat[7], 1'b1);
        pay_on <= 1'b0;
        repeat (3 * T2 * RCP) @(negedge ref_clk);
        check(rx_enable, 1'b1);
        wb(`ADDR_SEQ_CTRL, 1'b1, 32'h0000_0002);
        pre_on <= 1'b0;
        repeat (8) @(negedge ref_clk);
        check(rx_enable, 1'b0);
    endtask
    task automatic t_sync;
        int c;
        // As above, but 101 on sync word and timeout back to low power
        wb(`ADDR_SEQ_CONFIG, 1'b1, 32'h0000_02B9);
        wb(`ADDR_RX_TIMEOUT, 1'b1, 32'h0000_0002);
        wb(`ADDR_SEQ_CTRL, 1'b1, 32'h0000_0001);
        poll(2 * RCP, (T1 + T2) * RCP);
        @(posedge ref_clk);
        pre_on <= 1'b1;
        poll(T2 * RCP, (T1 + T2) * RCP);
        @(posedge ref_clk);
        sync_on <= 1'b1;
        wait_sig(1, 1'b1, c);
        repeat (3 * T2 * RCP) @(negedge ref_clk);
        check(rx_enable, 1'b1);
        wb(`ADDR_SEQ_CTRL, 1'b1, 32'h0000_0002);
        {pre_on, sync_on} <= 2'b00;
    endtask
    task automatic t_pins;
        logic [2:0] pat [2] = '{3'b101, 3'b010};
        logic [4:0] exp [2] = '{5'b01001, 5'b00010};
        wb(`ADDR_PIN_MAP, 1'b1, 32'h0000_0301);
        foreach (pat[i]) begin
            @(posedge ref_clk);
            {checksum_pass_flag, queue_threshold_flag,
             queue_drained_flag} <= pat[i];
            repeat (6) @(negedge ref_clk);
            check(general_output_pin & 5'b01011, exp[i]);
        end
    endtask
    initial begin
        {rst, reset_input_low, pre_on, sync_on, pay_on} = 5'b11000;
        {checksum_pass_flag, queue_threshold_flag, queue_drained_flag} = '0;
        {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_dat_i} = '0;
        repeat (16) @(posedge ref_clk);
        rst <= 1'b0;
        t_ready;
        t_regs;
        t_nosig;
        t_pre;
        t_sync;
        t_pins;
        print_verdict;
    end
endmodule // listen_sequencer_and_reset_test
bind listen_sequencer_and_reset listen_seq_checker u_chk (.*);
